/* design/pfpc_defs.vh */
`ifndef PFPC_DEFS_VH
`define PFPC_DEFS_VH
// ----------------------------------------
// clock in MHz, delay figures in microseconds
// ----------------------------------------
`define PFPC_CLK_MHZ 250
`define PFPC_OCH_DLY_US 1000
`define PFPC_ODC_DLY_US 1000
`define PFPC_ODR_DLY_US 1000
`define PFPC_OCU_DLY_US 10
`define PFPC_OCR_DLY_US 1000
`define PFPC_XCH_DLY_US 1000
`define PFPC_XCR_DLY_US 1000
`define PFPC_SHC_DLY_US 1
// ----------------------------------------
// delay counts in clock cycles
// ----------------------------------------
`define PFPC_CYC(us) ((us) * `PFPC_CLK_MHZ)
// test mode divides counter delays by this factor
`define PFPC_TEST_DIV 64
`define PFPC_CNT_W 20
`define PFPC_SHC_W 10
`endif

/* design/pfpc_delay.v */
`default_nettype none
// ----------------------------------------
// qualification delay: out follows cond after DLY cycles held
// ----------------------------------------
module pfpc_delay #(
  parameter W = 20,
  parameter [W-1:0] DLY = 1,
  parameter [W-1:0] DLY_FAST = 1
) (
  input wire clk,
  input wire rst_n,
  input wire fast,
  input wire run,
  input wire cond,
  output reg hit
);
  reg [W-1:0] cnt_r;
  wire [W-1:0] lim;
  assign lim = fast ? DLY_FAST : DLY;
  // restart whenever condition drops or the counter is held off
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {W{1'b0}};
      hit <= 1'b0;
    end else if (!run || !cond) begin
      cnt_r <= {W{1'b0}};
      hit <= 1'b0;
    end else if (cnt_r + 1'b1 >= lim) begin
      hit <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
endmodule // pfpc_delay
`default_nettype wire

/* design/pfpc_ctrl.v */
// Behaviour
// - new over-charge suspends running over-discharge detection
// - over-discharge detection restarts after over-charge set
// - over-discharge after over-charge: 200k pull, no standby
// - over-discharge keeps running during over-current state
// - over-discharge state first aborts over-current detection
// - over-current first applies 30k pull-down
// - later over-discharge: drop 30k, 200k up, standby
// - over-discharge first: 200k pull-up and standby
// - short-circuit detection runs fully independent
// - no charger fault while discharge faults active
// - charger delay starts once discharge gate high
// - over-current, short-circuit drive discharge gate low
// - charger fault lowers charge gate, cancels if cleared
// - test input shortens counter delays, not short
`include "pfpc_defs.vh"
`default_nettype none
module pfpc_ctrl #(
  parameter [`PFPC_CNT_W-1:0] OCH_CYC = `PFPC_CYC(`PFPC_OCH_DLY_US),
  parameter [`PFPC_CNT_W-1:0] ODC_CYC = `PFPC_CYC(`PFPC_ODC_DLY_US),
  parameter [`PFPC_CNT_W-1:0] ODR_CYC = `PFPC_CYC(`PFPC_ODR_DLY_US),
  parameter [`PFPC_CNT_W-1:0] OCU_CYC = `PFPC_CYC(`PFPC_OCU_DLY_US),
  parameter [`PFPC_CNT_W-1:0] OCR_CYC = `PFPC_CYC(`PFPC_OCR_DLY_US),
  parameter [`PFPC_CNT_W-1:0] XCH_CYC = `PFPC_CYC(`PFPC_XCH_DLY_US),
  parameter [`PFPC_CNT_W-1:0] XCR_CYC = `PFPC_CYC(`PFPC_XCR_DLY_US),
  parameter [`PFPC_SHC_W-1:0] SHC_CYC = `PFPC_CYC(`PFPC_SHC_DLY_US)
) (
  input wire CLOCK,
  input wire RESETN,
  input wire OVCHG_CMP,
  input wire OVDIS_CMP,
  input wire OVCUR_CMP,
  input wire SHORT_CMP,
  input wire XCHG_CMP,
  input wire TEST_FAST,
  output reg DIS_GATE,
  output reg CHG_GATE,
  output reg PULLUP_EN,
  output reg PULLDN_EN,
  output reg STANDBY,
  output reg OVCHG_ST,
  output reg OVDIS_ST,
  output reg OVCUR_ST,
  output reg SHORT_ST,
  output reg XCHG_ST
);
  localparam W = `PFPC_CNT_W;
  localparam [W-1:0] D = `PFPC_TEST_DIV;
  // ----------------------------------------
  // input synchronisers (comparators are asynchronous)
  // ----------------------------------------
  reg [5:0] s1_r;
  reg [5:0] s2_r;
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
    end else begin
      s1_r <= {TEST_FAST, XCHG_CMP, SHORT_CMP, OVCUR_CMP, OVDIS_CMP,
               OVCHG_CMP};
      s2_r <= s1_r;
    end
  end
  wire och_c = s2_r[0];
  wire odc_c = s2_r[1];
  wire ocu_c = s2_r[2];
  wire shc_c = s2_r[3];
  wire xch_c = s2_r[4];
  wire fast = s2_r[5];
  // ----------------------------------------
  // state flags, one per detection state
  // ----------------------------------------
  reg och_r;
  reg odc_r;
  reg ocu_r;
  reg shc_r;
  reg xch_r;
  reg dis_hi_r;
  // over-discharge state established while over-charge held
  reg od_after_oc_r;
  // ----------------------------------------
  // delay counters
  // ----------------------------------------
  wire och_hit;
  wire och_rel;
  wire odc_hit;
  wire odc_rel;
  wire ocu_hit;
  wire ocu_rel;
  wire shc_hit;
  wire xch_hit;
  wire xch_rel;
  // ----------------------------------------
  // shortened limits for test mode
  // ----------------------------------------
  // the added one keeps a limit of zero from arising
  localparam [W-1:0] OCH_FST = OCH_CYC / D + 1'b1;
  localparam [W-1:0] ODC_FST = ODC_CYC / D + 1'b1;
  localparam [W-1:0] ODR_FST = ODR_CYC / D + 1'b1;
  localparam [W-1:0] OCU_FST = OCU_CYC / D + 1'b1;
  localparam [W-1:0] OCR_FST = OCR_CYC / D + 1'b1;
  localparam [W-1:0] XCH_FST = XCH_CYC / D + 1'b1;
  localparam [W-1:0] XCR_FST = XCR_CYC / D + 1'b1;
  // ----------------------------------------
  // detection and release counters
  // ----------------------------------------
  // over-charge is always free to run and has precedence
  pfpc_delay #(
    .W(W),
    .DLY(OCH_CYC),
    .DLY_FAST(OCH_FST)
  ) u_och (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(fast),
    .run(!och_r),
    .cond(och_c),
    .hit(och_hit)
  );
  // over-charge release runs only while the state is held
  pfpc_delay #(
    .W(W),
    .DLY(OCH_CYC),
    .DLY_FAST(OCH_FST)
  ) u_ochr (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(fast),
    .run(och_r),
    .cond(!och_c),
    .hit(och_rel)
  );
  // suspended while over-charge detection counts; restart after it
  pfpc_delay #(
    .W(W),
    .DLY(ODC_CYC),
    .DLY_FAST(ODC_FST)
  ) u_odc (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(fast),
    .run(!odc_r && !(och_c && !och_r)),
    .cond(odc_c),
    .hit(odc_hit)
  );
  // over-discharge release, counted while the state stands
  pfpc_delay #(
    .W(W),
    .DLY(ODR_CYC),
    .DLY_FAST(ODR_FST)
  ) u_odr (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(fast),
    .run(odc_r),
    .cond(!odc_c),
    .hit(odc_rel)
  );
  // over-current detection dies once over-discharge state is set
  pfpc_delay #(
    .W(W),
    .DLY(OCU_CYC),
    .DLY_FAST(OCU_FST)
  ) u_ocu (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(fast),
    .run(!ocu_r && !odc_r),
    .cond(ocu_c),
    .hit(ocu_hit)
  );
  // one release serves both over-current and short-circuit
  pfpc_delay #(
    .W(W),
    .DLY(OCR_CYC),
    .DLY_FAST(OCR_FST)
  ) u_ocur (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(fast),
    .run(ocu_r || shc_r),
    .cond(!ocu_c && !shc_c),
    .hit(ocu_rel)
  );
  // short delay is fixed: test input has no effect on it
  pfpc_delay #(
    .W(`PFPC_SHC_W),
    .DLY(SHC_CYC),
    .DLY_FAST(SHC_CYC)
  ) u_shc (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(1'b0),
    .run(!shc_r),
    .cond(shc_c),
    .hit(shc_hit)
  );
  // charger delay waits for the discharge gate to be high
  pfpc_delay #(
    .W(W),
    .DLY(XCH_CYC),
    .DLY_FAST(XCH_FST)
  ) u_xch (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(fast),
    .run(!xch_r && dis_hi_r && !odc_r && !ocu_r && !shc_r),
    .cond(xch_c),
    .hit(xch_hit)
  );
  // charger release, counted while the charger state is held
  pfpc_delay #(
    .W(W),
    .DLY(XCR_CYC),
    .DLY_FAST(XCR_FST)
  ) u_xchr (
    .clk(CLOCK),
    .rst_n(RESETN),
    .fast(fast),
    .run(xch_r),
    .cond(!xch_c),
    .hit(xch_rel)
  );
  // ----------------------------------------
  // flag update, evaluated each cycle
  // ----------------------------------------
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      och_r <= 1'b0;
      odc_r <= 1'b0;
      ocu_r <= 1'b0;
      shc_r <= 1'b0;
      xch_r <= 1'b0;
      dis_hi_r <= 1'b1;
      od_after_oc_r <= 1'b0;
    end else begin
      if (och_hit)
        och_r <= 1'b1;
      else if (och_rel)
        och_r <= 1'b0;
      if (odc_hit) begin
        odc_r <= 1'b1;
        od_after_oc_r <= och_r;
      end else if (odc_rel) begin
        odc_r <= 1'b0;
        od_after_oc_r <= 1'b0;
      end
      // over-current state clears with its release or a later od
      if (ocu_hit)
        ocu_r <= 1'b1;
      else if (ocu_rel || odc_hit)
        ocu_r <= 1'b0;
      if (shc_hit)
        shc_r <= 1'b1;
      else if (ocu_rel)
        shc_r <= 1'b0;
      if (xch_hit)
        xch_r <= 1'b1;
      else if (xch_rel)
        xch_r <= 1'b0;
      dis_hi_r <= !(odc_r || ocu_r || shc_r);
    end
  end
  // ----------------------------------------
  // output drive, all registered
  // ----------------------------------------
  always @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      DIS_GATE <= 1'b1;
      CHG_GATE <= 1'b1;
      PULLUP_EN <= 1'b0;
      PULLDN_EN <= 1'b0;
      STANDBY <= 1'b0;
      OVCHG_ST <= 1'b0;
      OVDIS_ST <= 1'b0;
      OVCUR_ST <= 1'b0;
      SHORT_ST <= 1'b0;
      XCHG_ST <= 1'b0;
    end else begin
      DIS_GATE <= !(odc_r || ocu_r || shc_r);
      CHG_GATE <= !(och_r || xch_r);
      // pull-up to the positive supply for any od state
      PULLUP_EN <= odc_r;
      // 30k pull-down only when od not set (released on od)
      PULLDN_EN <= (ocu_r || shc_r) && !odc_r;
      // standby unless od came during over-charge
      STANDBY <= odc_r && !od_after_oc_r;
      OVCHG_ST <= och_r;
      OVDIS_ST <= odc_r;
      OVCUR_ST <= ocu_r;
      SHORT_ST <= shc_r;
      XCHG_ST <= xch_r;
    end
  end
endmodule // pfpc_ctrl
`default_nettype wire

/* tb/pfpc_ctrl_assertions.sv */
`default_nettype none
// ----------------------------------------
// port checker for the fault arbiter
// ----------------------------------------
module pfpc_chk (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic DIS_GATE,
  input wire logic CHG_GATE,
  input wire logic PULLUP_EN,
  input wire logic PULLDN_EN,
  input wire logic STANDBY,
  input wire logic OVCHG_ST,
  input wire logic OVDIS_ST,
  input wire logic OVCUR_ST,
  input wire logic SHORT_ST,
  input wire logic XCHG_ST
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // gate outputs switch in the same cycle as the state flag; checked one cycle on
  property p_gate; $rose(OVCUR_ST) || $rose(SHORT_ST) |=> !DIS_GATE;
  endproperty
  a_gate: assert property (p_gate)
    else $error("discharge gate stayed on");
  property p_dn; $rose(OVCUR_ST) && !OVDIS_ST && !OVCHG_ST |=> PULLDN_EN;
  endproperty
  a_dn: assert property (p_dn)
    else $error("pull-down not applied");
  property p_sb; $rose(OVDIS_ST) && !OVCHG_ST |=>
    PULLUP_EN && STANDBY && !PULLDN_EN; endproperty
  a_sb: assert property (p_sb)
    else $error("standby entry wrong");
  property p_nsb; $rose(OVDIS_ST) && OVCHG_ST |=> PULLUP_EN && !STANDBY;
  endproperty
  a_nsb: assert property (p_nsb)
    else $error("standby entered under over-charge");
  property p_abort; OVDIS_ST ##1 OVDIS_ST |=> !OVCUR_ST; endproperty
  a_abort: assert property (p_abort)
    else $error("over-current kept beside over-discharge");
  property p_supp; OVDIS_ST || OVCUR_ST || SHORT_ST |-> !$rose(XCHG_ST);
  endproperty
  a_supp: assert property (p_supp)
    else $error("charger fault during discharge fault");
  // charger fault needs the gate high now and 8 cycles before
  property p_xdly; $rose(XCHG_ST) |-> DIS_GATE && $past(DIS_GATE, 8);
  endproperty
  a_xdly: assert property (p_xdly)
    else $error("charger fault with gate low");
  property p_cg; $rose(XCHG_ST) |=> !CHG_GATE; endproperty
  a_cg: assert property (p_cg)
    else $error("charge gate stayed on");
endmodule // pfpc_chk
bind pfpc_ctrl pfpc_chk i_chk (.CLOCK(CLOCK), .RESETN(RESETN),
  .DIS_GATE(DIS_GATE), .CHG_GATE(CHG_GATE), .PULLUP_EN(PULLUP_EN),
  .PULLDN_EN(PULLDN_EN), .STANDBY(STANDBY), .OVCHG_ST(OVCHG_ST),
  .OVDIS_ST(OVDIS_ST), .OVCUR_ST(OVCUR_ST), .SHORT_ST(SHORT_ST),
  .XCHG_ST(XCHG_ST));
`default_nettype wire

/* tb/pfpc_fet_model.sv */
`default_nettype none
// external fets: conduct while their gate is high
module pfpc_fet_model (
  input wire logic dis_gate,
  input wire logic chg_gate,
  output logic dis_on,
  output logic chg_on
);
  timeunit 1ns;
  timeprecision 1ps;
  assign dis_on = dis_gate;
  assign chg_on = chg_gate;
endmodule // pfpc_fet_model
`default_nettype wire

/* tb/pfpc_ctrl_tb_top.sv */
`default_nettype none
module pfpc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rn = 0, oc = 0, od = 0, ou = 0, sc = 0, xc = 0, tf = 0;
  wire dg, cg, pu, pd, sb, dn, cn;
  wire [4:0] st;
  int num_errors = 0, check_count = 0, n, nn;
  always #2 clk = ~clk;
  pfpc_ctrl #(.OCH_CYC(20'h14), .ODC_CYC(20'h14), .OCU_CYC(20'h10),
    .XCH_CYC(20'h14), .SHC_CYC(10'h4)) i_dut (.CLOCK(clk), .RESETN(rn),
    .OVCHG_CMP(oc), .OVDIS_CMP(od), .OVCUR_CMP(ou), .SHORT_CMP(sc),
    .XCHG_CMP(xc), .TEST_FAST(tf), .DIS_GATE(dg), .CHG_GATE(cg),
    .PULLUP_EN(pu), .PULLDN_EN(pd), .STANDBY(sb), .OVCHG_ST(st[0]),
    .OVDIS_ST(st[1]), .OVCUR_ST(st[2]), .SHORT_ST(st[3]), .XCHG_ST(st[4]));
  pfpc_fet_model i_fet (.dis_gate(dg), .chg_gate(cg), .dis_on(dn),
    .chg_on(cn));
  task chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: output mismatch", $time);
    end
  endtask
  // bounded wait on one state flag, n holds the cycles spent
  task wt(input int b);
    n = 0;
    while (st[b] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
  endtask
  task rst;
    @(negedge clk);
    {oc, od, ou, sc, xc, tf, rn} = '0;
    repeat (4) @(negedge clk);
    rn = 1;
    @(negedge clk);
  endtask
  task t_cur_dis;
    ou = 1; wt(2); nn = n;
    repeat (2) @(negedge clk);
    chk(dn, 0); chk(pd, 1); chk(sb, 0);
    od = 1; wt(1);
    repeat (2) @(negedge clk);
    chk(st[2], 0); chk(pd, 0); chk(pu, 1); chk(sb, 1);
  endtask
  task t_dis_cur;
    od = 1; wt(1); ou = 1;
    repeat (60) @(negedge clk);
    chk(st[2], 0); chk(pu, 1); chk(sb, 1);
    sc = 1; repeat (12) @(negedge clk);
    chk(st[3], 1); chk(dn, 0);
  endtask
  task t_chg_dis;
    od = 1; repeat (10) @(negedge clk);
    oc = 1; wt(0);
    chk(st[0], 1); chk(st[1], 0);
    wt(1); chk(st[1], 1);
    repeat (2) @(negedge clk);
    chk(sb, 0); chk(pu, 1);
  endtask
  task t_xchg;
    xc = 1; repeat (8) @(negedge clk);
    xc = 0; repeat (40) @(negedge clk);
    chk(st[4], 0);
    xc = 1; wt(4); repeat (2) @(negedge clk);
    chk(st[4], 1); chk(cn, 0);
    rst; ou = 1; wt(2); xc = 1;
    repeat (60) @(negedge clk);
    chk(st[4], 0);
  endtask
  task t_fast;
    tf = 1; ou = 1; wt(2);
    chk(st[2], 1); chk(n < nn, 1);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst; t_cur_dis;
    rst; t_dis_cur;
    rst; t_chg_dis;
    rst; t_xchg;
    rst; t_fast;
    end_of_test;
  end
  // the scenarios need about 400 cycles
  initial begin
    #40000;
    num_errors++;
    end_of_test;
  end
endmodule // pfpc_ctrl_tb_top
`default_nettype wire
